// *** hwtb_pkg.sv ***
// Constants, field layouts and access-space codes for the thread barrier.
// Assumes one core clock; used by the barrier top and its unit module.
package hwtb_pkg;

	// Structure sizes.
	localparam int NUM_UNITS = 2;
	localparam int STATUS_W = 24;
	localparam int NUM_BLADES = 12;
	localparam int NUM_SLOTS = 6;
	localparam int BLADE_W = 4;
	localparam int BIT_W = 5;
	localparam int SLOT_W = 3;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 64;

	// Initialization data word layout.
	localparam int INIT_FLAG_BIT = 48;
	localparam int INIT_MASK_LO = 24;
	localparam int INIT_VALUE_LO = 0;

	// Assignment data word layout.
	localparam int ASG_VALID_BIT = 63;
	localparam int ASG_UNIT_BIT = 9;
	localparam int ASG_BLADE_LO = 5;
	localparam int ASG_BIT_LO = 0;

	// Window data bit.
	localparam int WIN_BIT = 0;

	// Address fields: unit and blade for init, slot for assign and window.
	localparam int VA_UNIT_BIT = 9;
	localparam int VA_BLADE_LO = 5;
	localparam int VA_SLOT_LO = 4;

	// Reset values.
	localparam logic [STATUS_W-1:0] STATUS_RST = 24'h000000;
	localparam logic [NUM_BLADES-1:0] FLAG_RST = 12'h000;

	// Access spaces a thread may address.
	typedef enum logic [1:0] {
		SPACE_NONE = 2'b00,
		SPACE_INIT = 2'b01,
		SPACE_ASSIGN = 2'b10,
		SPACE_WINDOW = 2'b11
	} hwtb_space_t;

	// True when a blade index names an existing blade.
	function automatic logic blade_ok(input logic [BLADE_W-1:0] b);
		blade_ok = (32'(b) < NUM_BLADES);
	endfunction : blade_ok

	// True when a status bit index names an existing bit.
	function automatic logic bit_ok(input logic [BIT_W-1:0] b);
		bit_ok = (32'(b) < STATUS_W);
	endfunction : bit_ok

	// True when a slot index names one of the window slots.
	function automatic logic slot_ok(input logic [SLOT_W-1:0] s);
		slot_ok = (32'(s) < NUM_SLOTS);
	endfunction : slot_ok

endpackage : hwtb_pkg

// *** hwtb_unit_if.sv ***
// Carrier between the barrier top and one barrier unit.
// Assumes at most one strobe per cycle from the top.
`timescale 1ns/1ps
`default_nettype none
interface hwtb_unit_if;
	// Initialization write.
	logic init_we;
	logic [hwtb_pkg::BLADE_W-1:0] init_blade;
	logic init_flag;
	logic [hwtb_pkg::STATUS_W-1:0] init_mask;
	logic [hwtb_pkg::STATUS_W-1:0] init_value;
	// Single status bit write from a window.
	logic bit_we;
	logic [hwtb_pkg::BIT_W-1:0] bit_idx;
	logic bit_val;
	// Unit state.
	logic [hwtb_pkg::STATUS_W-1:0] status;
	logic [hwtb_pkg::NUM_BLADES-1:0][hwtb_pkg::STATUS_W-1:0] mask;
	logic [hwtb_pkg::NUM_BLADES-1:0] flag;
	logic [hwtb_pkg::NUM_BLADES-1:0] changed;

	modport unit (
		input init_we, init_blade, init_flag, init_mask, init_value,
		input bit_we, bit_idx, bit_val,
		output status, mask, flag, changed
	);
	modport ctrl (
		output init_we, init_blade, init_flag, init_mask, init_value,
		output bit_we, bit_idx, bit_val,
		input status, mask, flag, changed
	);
endinterface : hwtb_unit_if
`default_nettype wire

// *** hwtb_unit.sv ***
// One barrier unit: status vector, blade masks and last-sync flags.
// Assumes the top sends at most one write strobe per cycle.
`timescale 1ns/1ps
`default_nettype none
module hwtb_unit (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Link to the barrier top.
	hwtb_unit_if.unit bus
);

	logic [hwtb_pkg::NUM_BLADES-1:0] next_flag;
	logic [hwtb_pkg::NUM_BLADES-1:0] synced;
	logic [hwtb_pkg::NUM_BLADES-1:0] common;

	// Status vector; only masked bits change on an init write.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus.status <= hwtb_pkg::STATUS_RST;
		end else if (bus.init_we) begin
			bus.status <= (bus.status & ~bus.init_mask) | (bus.init_mask & bus.init_value);
		end else if (bus.bit_we) begin
			bus.status[bus.bit_idx] <= bus.bit_val;
		end
	end

	// Sync test per blade from the registered status, so a status write
	// only reaches the flag one edge later and earlier reads see the old flag.
	always_comb begin
		for (int b = 0; b < hwtb_pkg::NUM_BLADES; b++) begin
			common[b] = ((bus.status & bus.mask[b]) == bus.mask[b]) && (bus.mask[b] != '0);
			synced[b] = common[b] || ((bus.status & bus.mask[b]) == '0);
			next_flag[b] = synced[b] ? common[b] : bus.flag[b];
			if (bus.init_we && (32'(bus.init_blade) == b)) begin
				next_flag[b] = bus.init_flag;
			end
		end
	end

	// Masks, flags and change pulses; flags move in one edge, never partly.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus.mask <= '0;
			bus.flag <= hwtb_pkg::FLAG_RST;
			bus.changed <= '0;
		end else begin
			for (int b = 0; b < hwtb_pkg::NUM_BLADES; b++) begin
				if (bus.init_we && (32'(bus.init_blade) == b)) begin
					bus.mask[b] <= bus.init_mask;
				end
			end
			bus.flag <= next_flag;
			bus.changed <= next_flag ^ bus.flag;
		end
	end

endmodule : hwtb_unit
`default_nettype wire

// *** hwtb_barrier.sv ***
// Thread barrier top: access decode, per-thread window tables, two units.
// Assumes one access per cycle from the thread arbiter, issued in order.
`timescale 1ns/1ps
`default_nettype none
module hwtb_barrier #(
	parameter int THREADS = 8,
	parameter int THR_W = 3
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Access request from a thread.
	input wire logic req_valid,
	input wire logic [THR_W-1:0] req_thread,
	input wire hwtb_pkg::hwtb_space_t req_space,
	input wire logic req_write,
	input wire logic [hwtb_pkg::ADDR_W-1:0] req_addr,
	input wire logic [hwtb_pkg::DATA_W-1:0] req_wdata,
	// Read answer.
	output logic resp_valid,
	output logic [hwtb_pkg::DATA_W-1:0] resp_rdata,
	// Wake-up pulses, one per thread.
	output logic [THREADS-1:0] wake
);

	// Unit links, one interface per unit.
	hwtb_unit_if uif [hwtb_pkg::NUM_UNITS] ();

	// Per-thread window tables; separate rows keep threads apart.
	logic map_valid [THREADS][hwtb_pkg::NUM_SLOTS];
	logic map_unit [THREADS][hwtb_pkg::NUM_SLOTS];
	logic [hwtb_pkg::BLADE_W-1:0] map_blade [THREADS][hwtb_pkg::NUM_SLOTS];
	logic [hwtb_pkg::BIT_W-1:0] map_bit [THREADS][hwtb_pkg::NUM_SLOTS];

	// Unit state gathered for indexed reads.
	logic [hwtb_pkg::STATUS_W-1:0] unit_status [hwtb_pkg::NUM_UNITS];
	logic [hwtb_pkg::NUM_BLADES-1:0][hwtb_pkg::STATUS_W-1:0] unit_mask [hwtb_pkg::NUM_UNITS];
	logic [hwtb_pkg::NUM_BLADES-1:0] unit_flag [hwtb_pkg::NUM_UNITS];
	logic [hwtb_pkg::NUM_BLADES-1:0] unit_changed [hwtb_pkg::NUM_UNITS];

	// Decoded request fields.
	logic va_unit;
	logic [hwtb_pkg::BLADE_W-1:0] va_blade;
	logic [hwtb_pkg::SLOT_W-1:0] va_slot;
	logic thr_ok;
	logic slot_hit;
	logic is_init;
	logic is_assign;
	logic is_window;
	logic init_hit;
	logic win_hit;
	logic ent_unit;
	logic [hwtb_pkg::BLADE_W-1:0] ent_blade;
	logic [hwtb_pkg::BIT_W-1:0] ent_bit;
	logic ent_valid;
	logic asg_valid;
	logic asg_unit;
	logic [hwtb_pkg::BLADE_W-1:0] asg_blade;
	logic [hwtb_pkg::BIT_W-1:0] asg_bit;
	logic [hwtb_pkg::DATA_W-1:0] next_rdata;
	logic [THREADS-1:0] next_wake;

	// Field extraction from address and write data.
	assign va_unit = req_addr[hwtb_pkg::VA_UNIT_BIT];
	assign va_blade = req_addr[hwtb_pkg::VA_BLADE_LO +: hwtb_pkg::BLADE_W];
	assign va_slot = req_addr[hwtb_pkg::VA_SLOT_LO +: hwtb_pkg::SLOT_W];
	assign asg_valid = req_wdata[hwtb_pkg::ASG_VALID_BIT];
	assign asg_unit = req_wdata[hwtb_pkg::ASG_UNIT_BIT];
	assign asg_blade = req_wdata[hwtb_pkg::ASG_BLADE_LO +: hwtb_pkg::BLADE_W];
	assign asg_bit = req_wdata[hwtb_pkg::ASG_BIT_LO +: hwtb_pkg::BIT_W];

	// Any thread of this chip is accepted, nothing reaches other chips.
	assign thr_ok = (32'(req_thread) < THREADS);
	assign slot_hit = thr_ok && hwtb_pkg::slot_ok(va_slot);
	assign is_init = req_valid && thr_ok && (req_space == hwtb_pkg::SPACE_INIT);
	assign is_assign = req_valid && slot_hit && (req_space == hwtb_pkg::SPACE_ASSIGN);
	assign is_window = req_valid && slot_hit && (req_space == hwtb_pkg::SPACE_WINDOW);
	assign init_hit = is_init && hwtb_pkg::blade_ok(va_blade);

	// Selected window entry of the requesting thread only.
	always_comb begin
		ent_valid = 1'b0;
		ent_unit = 1'b0;
		ent_blade = '0;
		ent_bit = '0;
		if (slot_hit) begin
			ent_valid = map_valid[req_thread][va_slot];
			ent_unit = map_unit[req_thread][va_slot];
			ent_blade = map_blade[req_thread][va_slot];
			ent_bit = map_bit[req_thread][va_slot];
		end
	end

	// Unassigned windows drop the access without any error signal.
	assign win_hit = is_window && ent_valid;

	// Two identical units, each driven only by requests naming it.
	for (genvar u = 0; u < hwtb_pkg::NUM_UNITS; u++) begin : g_unit
		assign uif[u].init_we = init_hit && req_write && (va_unit == 1'(u));
		assign uif[u].init_blade = va_blade;
		assign uif[u].init_flag = req_wdata[hwtb_pkg::INIT_FLAG_BIT];
		assign uif[u].init_mask = req_wdata[hwtb_pkg::INIT_MASK_LO +: hwtb_pkg::STATUS_W];
		assign uif[u].init_value = req_wdata[hwtb_pkg::INIT_VALUE_LO +: hwtb_pkg::STATUS_W];
		assign uif[u].bit_we = win_hit && req_write && (ent_unit == 1'(u));
		assign uif[u].bit_idx = ent_bit;
		assign uif[u].bit_val = req_wdata[hwtb_pkg::WIN_BIT];
		assign unit_status[u] = uif[u].status;
		assign unit_mask[u] = uif[u].mask;
		assign unit_flag[u] = uif[u].flag;
		assign unit_changed[u] = uif[u].changed;

		hwtb_unit u_unit (
			.clk(clk),
			.resetn(resetn),
			.bus(uif[u])
		);
	end

	// Window tables: map on valid writes naming real resources, release on
	// valid clear; a bad map request leaves the old entry untouched.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int t = 0; t < THREADS; t++) begin
				for (int s = 0; s < hwtb_pkg::NUM_SLOTS; s++) begin
					map_valid[t][s] <= 1'b0;
					map_unit[t][s] <= 1'b0;
					map_blade[t][s] <= '0;
					map_bit[t][s] <= '0;
				end
			end
		end else if (is_assign && req_write) begin
			if (!asg_valid) begin
				map_valid[req_thread][va_slot] <= 1'b0;
			end else if (hwtb_pkg::blade_ok(asg_blade) && hwtb_pkg::bit_ok(asg_bit)) begin
				map_valid[req_thread][va_slot] <= 1'b1;
				map_unit[req_thread][va_slot] <= asg_unit;
				map_blade[req_thread][va_slot] <= asg_blade;
				map_bit[req_thread][va_slot] <= asg_bit;
			end
		end
	end

	// Read data; undefined cases answer zero so tests see a fixed value.
	always_comb begin
		next_rdata = '0;
		unique case (req_space)
			hwtb_pkg::SPACE_INIT: begin
				if (init_hit) begin
					next_rdata[hwtb_pkg::INIT_FLAG_BIT] = unit_flag[va_unit][va_blade];
					next_rdata[hwtb_pkg::INIT_MASK_LO +: hwtb_pkg::STATUS_W] = unit_mask[va_unit][va_blade];
					next_rdata[hwtb_pkg::INIT_VALUE_LO +: hwtb_pkg::STATUS_W] = unit_status[va_unit];
				end
			end
			hwtb_pkg::SPACE_ASSIGN: begin
				if (slot_hit) begin
					next_rdata[hwtb_pkg::ASG_VALID_BIT] = ent_valid;
					next_rdata[hwtb_pkg::ASG_UNIT_BIT] = ent_unit;
					next_rdata[hwtb_pkg::ASG_BLADE_LO +: hwtb_pkg::BLADE_W] = ent_blade;
					next_rdata[hwtb_pkg::ASG_BIT_LO +: hwtb_pkg::BIT_W] = ent_bit;
				end
			end
			hwtb_pkg::SPACE_WINDOW: begin
				if (win_hit) begin
					next_rdata[hwtb_pkg::WIN_BIT] = unit_flag[ent_unit][ent_blade];
				end
			end
			hwtb_pkg::SPACE_NONE: begin
				next_rdata = '0;
			end
		endcase
	end

	// Read answer one edge after the request. The flag is sampled from its
	// register, so a read issued before a status write sees the old flag.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			resp_valid <= 1'b0;
			resp_rdata <= '0;
		end else begin
			resp_valid <= req_valid && !req_write && thr_ok && (req_space != hwtb_pkg::SPACE_NONE);
			resp_rdata <= next_rdata;
		end
	end

	// Wake any thread with a live window on a blade whose flag just moved.
	always_comb begin
		for (int t = 0; t < THREADS; t++) begin
			next_wake[t] = 1'b0;
			for (int s = 0; s < hwtb_pkg::NUM_SLOTS; s++) begin
				if (map_valid[t][s] && unit_changed[map_unit[t][s]][map_blade[t][s]]) begin
					next_wake[t] = 1'b1;
				end
			end
		end
	end

	// Wake pulses are registered to keep the output glitch free.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wake <= '0;
		end else begin
			wake <= next_wake;
		end
	end

endmodule : hwtb_barrier
`default_nettype wire

// *** hwtb_barrier_properties.sv ***
// Port-level assertions for the thread barrier top.
// Bound to hwtb_barrier from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module hwtb_barrier_properties #(
	parameter int THREADS = 8,
	parameter int THR_W = 3
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Request.
	input wire logic req_valid,
	input wire logic [THR_W-1:0] req_thread,
	input wire hwtb_pkg::hwtb_space_t req_space,
	input wire logic req_write,
	input wire logic [hwtb_pkg::ADDR_W-1:0] req_addr,
	input wire logic [hwtb_pkg::DATA_W-1:0] req_wdata,
	// Answer and wake-up.
	input wire logic resp_valid,
	input wire logic [hwtb_pkg::DATA_W-1:0] resp_rdata,
	input wire logic [THREADS-1:0] wake
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Any write, helper for the wake-up cause.
	wire logic wr = req_valid && req_write;
	// A read from an existing thread to a real space.
	sequence s_read_taken;
		req_valid && !req_write && (32'(req_thread) < THREADS) && (req_space != hwtb_pkg::SPACE_NONE);
	endsequence
	sequence s_write_taken;
		req_valid && req_write;
	endsequence
	a_read_answer: assert property (s_read_taken |=> resp_valid) else $error("read not answered");
	a_write_silent: assert property (s_write_taken |=> !resp_valid) else $error("write answered");
	a_resp_cause: assert property (!$past(req_valid && !req_write) |-> !resp_valid) else $error("stray answer");
	a_bad_thread: assert property (req_valid && (32'(req_thread) >= THREADS) |=> !resp_valid) else $error("bad thread");
	a_none_space: assert property (req_valid && req_space == hwtb_pkg::SPACE_NONE |=> !resp_valid) else $error("none");
	a_window_bits: assert property (resp_valid && $past(req_space) == hwtb_pkg::SPACE_WINDOW
		|-> resp_rdata[63:1] == '0) else $error("window read has extra bits");
	a_assign_layout: assert property (resp_valid && $past(req_space) == hwtb_pkg::SPACE_ASSIGN
		|-> resp_rdata[62:10] == '0) else $error("assign read layout");
	a_init_layout: assert property (resp_valid && $past(req_space) == hwtb_pkg::SPACE_INIT
		|-> resp_rdata[63:49] == '0) else $error("init read layout");
	// An init write that sets the flag directly wakes two edges after the write.
	// A status change wakes three edges after the write.
	a_wake_cause: assert property (wake != '0 |-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
		else $error("wake without write");
	// Reset must silence the outputs even though the other checks are off then.
	a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !resp_valid && wake == '0)
		else $error("outputs busy after reset");
endmodule : hwtb_barrier_properties
`default_nettype wire

// *** hwtb_thread_model.sv ***
// Model of the processor threads issuing barrier accesses.
// Drives at the falling edge; one access at a time, in program order.
`timescale 1ns/1ps
`default_nettype none
module hwtb_thread_model #(
	parameter int THR_W = 3
) (
	// Clock.
	input wire logic clk,
	// Request.
	output logic req_valid,
	output logic [THR_W-1:0] req_thread,
	output hwtb_pkg::hwtb_space_t req_space,
	output logic req_write,
	output logic [hwtb_pkg::ADDR_W-1:0] req_addr,
	output logic [hwtb_pkg::DATA_W-1:0] req_wdata,
	// Answer.
	input wire logic resp_valid,
	input wire logic [hwtb_pkg::DATA_W-1:0] resp_rdata
);
	// Idle lines at time zero.
	initial begin
		req_valid = 1'b0;
		req_thread = '0;
		req_space = hwtb_pkg::SPACE_NONE;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
	end
	// Each access waits for the previous one, which also acts as the store fence.
	task automatic access(input logic [THR_W-1:0] t, input hwtb_pkg::hwtb_space_t s, input logic w,
		input logic [hwtb_pkg::ADDR_W-1:0] a, input logic [63:0] d, output logic rv, output logic [63:0] q);
		@(negedge clk);
		req_valid = 1'b1;
		req_thread = t;
		req_space = s;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge clk);
		rv = resp_valid;
		q = resp_rdata;
		// Address and data lines flip so stale values are never mistaken for live ones.
		req_valid = 1'b0;
		req_addr = ~req_addr;
		req_wdata = ~req_wdata;
	endtask : access
endmodule : hwtb_thread_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the thread barrier top.
// Uses hwtb_thread_model to issue accesses; six threads configured.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam hwtb_pkg::hwtb_space_t SI = hwtb_pkg::SPACE_INIT;
	localparam hwtb_pkg::hwtb_space_t SA = hwtb_pkg::SPACE_ASSIGN;
	localparam hwtb_pkg::hwtb_space_t SW = hwtb_pkg::SPACE_WINDOW;
	logic clk;
	logic resetn;
	logic req_valid;
	logic [2:0] req_thread;
	hwtb_pkg::hwtb_space_t req_space;
	logic req_write;
	logic [9:0] req_addr;
	logic [63:0] req_wdata;
	logic resp_valid;
	logic [63:0] resp_rdata;
	logic [5:0] wake;
	logic rv;
	logic [63:0] q;
	int num_errors;
	int check_count;
	int cycles = 0;
	hwtb_barrier #(.THREADS(6), .THR_W(3)) hwtb_barrier_i (.clk(clk), .resetn(resetn), .req_valid(req_valid),
		.req_thread(req_thread), .req_space(req_space), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata), .wake(wake));
	hwtb_thread_model #(.THR_W(3)) hwtb_thread_model_i (.clk(clk), .req_valid(req_valid),
		.req_thread(req_thread), .req_space(req_space), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata));
	// Clock of 40 ns.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	function automatic logic [9:0] ia(input logic u, input logic [3:0] b);
		ia = {u, b, 5'h00};
	endfunction : ia
	function automatic logic [9:0] sa(input logic [2:0] s);
		sa = {3'h0, s, 4'h0};
	endfunction : sa
	function automatic logic [63:0] asg(input logic v, input logic [3:0] b, input logic [4:0] n);
		asg = {v, 53'h0, 1'b0, b, n};
	endfunction : asg
	task automatic wr(input logic [2:0] t, input hwtb_pkg::hwtb_space_t s, input logic [9:0] a, input logic [63:0] d);
		logic r;
		logic [63:0] x;
		hwtb_thread_model_i.access(t, s, 1'b1, a, d, r, x);
	endtask : wr
	task automatic rd(input logic [2:0] t, input hwtb_pkg::hwtb_space_t s, input logic [9:0] a, input logic [63:0] e);
		logic r;
		logic [63:0] x;
		hwtb_thread_model_i.access(t, s, 1'b0, a, 64'h0, r, x);
		check(64'(r), 64'h1);
		check(x, e);
	endtask : rd
	task automatic finish_test;
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	// Hang guard, well above the roughly 70 cycles the run needs.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			finish_test();
		end
	end
	// Main sequence.
	initial begin
		resetn = 1'b0;
		num_errors = 0;
		check_count = 0;
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		rd(0, SI, ia(0, 3), 64'h0);
		rd(0, SA, sa(0), 64'h0);
		wr(0, SI, ia(0, 5), {15'h0, 1'b0, 24'hffffff, 24'hf0f0f0});
		wr(0, SI, ia(0, 3), {15'h0, 1'b0, 24'h000003, 24'h000001});
		rd(0, SI, ia(0, 3), {15'h0, 1'b0, 24'h000003, 24'hf0f0f1});
		rd(0, SI, ia(0, 5), {15'h0, 1'b0, 24'hffffff, 24'hf0f0f1});
		rd(0, SI, ia(1, 3), 64'h0);
		rd(0, SI, ia(0, 12), 64'h0);
		wr(0, SA, sa(0), asg(1, 3, 1));
		wr(1, SA, sa(2), asg(1, 3, 0));
		wr(0, SA, sa(0), asg(1, 12, 1));
		wr(0, SA, sa(0), asg(1, 3, 24));
		rd(0, SA, sa(0), asg(1, 3, 1));
		// Both selected bits now 1; the two mapped threads are woken.
		wr(0, SW, sa(0), 64'h1);
		repeat (2) @(negedge clk);
		check(64'(wake), 64'h3);
		rd(1, SW, sa(2), 64'h1);
		rd(2, SW, sa(2), 64'h0);
		wr(0, SW, sa(0), 64'h0);
		rd(1, SW, sa(2), 64'h1);
		wr(1, SW, sa(2), 64'h0);
		rd(0, SW, sa(0), 64'h0);
		// Released slot keeps its fields but drops writes.
		wr(0, SA, sa(0), 64'h0);
		rd(0, SA, sa(0), asg(0, 3, 1));
		wr(0, SW, sa(0), 64'h1);
		// A dropped window write must not move any flag, so nobody is woken.
		repeat (2) @(negedge clk);
		check(64'(wake), 64'h0);
		rd(0, SI, ia(0, 3), {15'h0, 1'b0, 24'h000003, 24'hf0f0f0});
		wr(0, SI, ia(1, 0), {15'h0, 1'b1, 24'h000020, 24'hffffff});
		rd(0, SI, ia(1, 0), {15'h0, 1'b1, 24'h000020, 24'h000020});
		hwtb_thread_model_i.access(3'h7, SI, 1'b0, ia(0, 3), 64'h0, rv, q);
		check(64'(rv), 64'h0);
		// A request to no access space is taken silently and answers nothing.
		hwtb_thread_model_i.access(3'h0, hwtb_pkg::SPACE_NONE, 1'b0, ia(0, 3), 64'h0, rv, q);
		check(64'(rv), 64'h0);
		check(q, 64'h0);
		finish_test();
	end
endmodule : tb
bind hwtb_barrier hwtb_barrier_properties #(.THREADS(THREADS), .THR_W(THR_W)) hwtb_barrier_properties_i (
	.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_thread(req_thread), .req_space(req_space),
	.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
	.resp_rdata(resp_rdata), .wake(wake));
`default_nettype wire
